/* hdl/dcc_regs.vh */
// Register addresses, field positions and reset values of the comparator block.
`ifndef DCC_REGS_VH
`define DCC_REGS_VH
`define DCC_ADDR_CMP0_CONTROL 8'h9b
`define DCC_ADDR_CMP1_CONTROL 8'h9a
`define DCC_ADDR_CMP0_MODE 8'h9d
`define DCC_ADDR_CMP1_MODE 8'h9c
`define DCC_ADDR_CMP0_MUX 8'h9f
`define DCC_ADDR_CMP1_MUX 8'h9e
`define DCC_BIT_ENABLE 7
`define DCC_BIT_RESULT 6
`define DCC_BIT_RISE 5
`define DCC_BIT_FALL 4
`define DCC_RST_CONTROL 8'h00
`define DCC_RST_MODE 8'h02
`define DCC_RST_MUX 8'hff
`define DCC_MODE_MASK 8'h33
`define DCC_MUX_MASK 8'h33
`define DCC_MUX_UNUSED 8'hcc
`endif

/* hdl/dcc_top.v */
// Digital control of two voltage comparators: registers, edge flags, outputs.
`timescale 1ns/10ps
`include "dcc_regs.vh"
module dcc_top (
  // Clock and reset
  input wire core_clk_in,
  input wire arst_n_in,
  // Special function register port
  input wire [7:0] sfr_addr_in,
  input wire [7:0] sfr_wdata_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  output reg [7:0] sfr_rdata_out,
  // Analog comparator front ends, index 1 is the second channel
  input wire [1:0] cmp_analog_in,
  output wire [1:0] cmp_power_en_out,
  output wire [3:0] pos_hyst_sel_out,
  output wire [3:0] neg_hyst_sel_out,
  output wire [3:0] resp_time_sel_out,
  output wire [3:0] pos_input_sel_out,
  output wire [3:0] neg_input_sel_out,
  // Port pin outputs and interrupt and reset requests
  output wire [1:0] raw_async_out,
  output wire [1:0] latched_sync_out,
  output wire [1:0] irq_out,
  output wire cmp0_reset_src_out
);

  // Per-channel state gathered for the read multiplexer.
  wire [15:0] ctrl_view;
  wire [15:0] mode_view;
  wire [15:0] mux_view;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      // Register state of this channel and its next values.
      reg [7:0] ctrl_reg;
      reg [7:0] ctrl_next;
      reg [7:0] mode_reg;
      reg [7:0] mode_next;
      reg [7:0] mux_reg;
      reg [7:0] mux_next;
      reg sync1_reg;
      reg sync1_next;
      reg sync2_reg;
      reg sync2_next;
      reg prev_reg;
      reg prev_next;
      reg rise_seen_flag_reg;
      reg rise_seen_flag_next;
      reg fall_seen_flag_reg;
      reg fall_seen_flag_next;

      // Address decode of this channel.
      wire [7:0] ctrl_addr;
      wire [7:0] mode_addr;
      wire [7:0] mux_addr;
      wire hit_ctrl;
      wire hit_mode;
      wire hit_mux;
      wire wr_ctrl;
      wire wr_mode;
      wire wr_mux;

      // Decoded fields and events.
      wire cmp_enable_bit;
      wire cmp_result_bit;
      wire rise_irq_enable;
      wire fall_irq_enable;
      wire rise_evt;
      wire fall_evt;
      wire [1:0] pos_hyst_sel;
      wire [1:0] neg_hyst_sel;
      wire [1:0] resp_time_sel;
      wire [1:0] pos_input_sel;
      wire [1:0] neg_input_sel;
      wire [7:0] ctrl_rd;

      assign ctrl_addr = (g == 0) ? `DCC_ADDR_CMP0_CONTROL :
        `DCC_ADDR_CMP1_CONTROL;
      assign mode_addr = (g == 0) ? `DCC_ADDR_CMP0_MODE :
        `DCC_ADDR_CMP1_MODE;
      assign mux_addr = (g == 0) ? `DCC_ADDR_CMP0_MUX :
        `DCC_ADDR_CMP1_MUX;
      assign hit_ctrl = (sfr_addr_in == ctrl_addr);
      assign hit_mode = (sfr_addr_in == mode_addr);
      assign hit_mux = (sfr_addr_in == mux_addr);
      // Write strobes qualified by address.
      assign wr_ctrl = sfr_wr_in && hit_ctrl;
      assign wr_mode = sfr_wr_in && hit_mode;
      assign wr_mux = sfr_wr_in && hit_mux;

      // Register fields of this channel.
      assign cmp_enable_bit = ctrl_reg[`DCC_BIT_ENABLE];
      assign cmp_result_bit = sync2_reg;
      assign rise_irq_enable = mode_reg[`DCC_BIT_RISE];
      assign fall_irq_enable = mode_reg[`DCC_BIT_FALL];
      assign pos_hyst_sel = ctrl_reg[3:2];
      assign neg_hyst_sel = ctrl_reg[1:0];
      assign resp_time_sel = mode_reg[1:0];
      assign pos_input_sel = mux_reg[1:0];
      assign neg_input_sel = mux_reg[5:4];

      // Edges are only seen on the synchronised sample pair.
      assign rise_evt = cmp_enable_bit && sync2_reg && !prev_reg;
      assign fall_evt = cmp_enable_bit && !sync2_reg && prev_reg;

      // Bit 6 and the flags are not storage of the control register.
      always @* begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
          ctrl_next = {sfr_wdata_in[7], 3'b000, sfr_wdata_in[3:0]};
        end
      end

      // Unused mode bits read zero and cannot be written.
      always @* begin
        mode_next = mode_reg;
        if (wr_mode) begin
          mode_next = sfr_wdata_in & `DCC_MODE_MASK;
        end
      end

      // Unused multiplexer bits read one and cannot be written.
      always @* begin
        mux_next = mux_reg;
        if (wr_mux) begin
          mux_next = (sfr_wdata_in & `DCC_MUX_MASK) | `DCC_MUX_UNUSED;
        end
      end

      // A disabled channel feeds a low level into the synchroniser.
      always @* begin
        sync1_next = cmp_analog_in[g] & cmp_enable_bit;
        sync2_next = sync1_reg;
        prev_next = sync2_reg;
      end

      // A hardware set wins over a software write in the same cycle.
      always @* begin
        rise_seen_flag_next = rise_seen_flag_reg;
        if (rise_evt) begin
          rise_seen_flag_next = 1'b1;
        end else if (wr_ctrl) begin
          rise_seen_flag_next = sfr_wdata_in[`DCC_BIT_RISE];
        end
      end

      // The falling flag follows the same priority.
      always @* begin
        fall_seen_flag_next = fall_seen_flag_reg;
        if (fall_evt) begin
          fall_seen_flag_next = 1'b1;
        end else if (wr_ctrl) begin
          fall_seen_flag_next = sfr_wdata_in[`DCC_BIT_FALL];
        end
      end

      // Register updates; reset values come from the register header.
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          ctrl_reg <= `DCC_RST_CONTROL;
        end else begin
          ctrl_reg <= ctrl_next;
        end
      end

      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          mode_reg <= `DCC_RST_MODE;
        end else begin
          mode_reg <= mode_next;
        end
      end

      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          mux_reg <= `DCC_RST_MUX;
        end else begin
          mux_reg <= mux_next;
        end
      end

      // Two flip-flops in series guard against a metastable sample.
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_reg <= 1'b0;
        end else begin
          sync1_reg <= sync1_next;
        end
      end

      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync2_reg <= 1'b0;
        end else begin
          sync2_reg <= sync2_next;
        end
      end

      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= prev_next;
        end
      end

      // Sticky edge flags.
      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          rise_seen_flag_reg <= 1'b0;
        end else begin
          rise_seen_flag_reg <= rise_seen_flag_next;
        end
      end

      always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          fall_seen_flag_reg <= 1'b0;
        end else begin
          fall_seen_flag_reg <= fall_seen_flag_next;
        end
      end

      // Settings driven to the analog front end.
      assign cmp_power_en_out[g] = cmp_enable_bit;
      assign pos_hyst_sel_out[2*g+1:2*g] = pos_hyst_sel;
      assign neg_hyst_sel_out[2*g+1:2*g] = neg_hyst_sel;
      assign resp_time_sel_out[2*g+1:2*g] = resp_time_sel;
      assign pos_input_sel_out[2*g+1:2*g] = pos_input_sel;
      assign neg_input_sel_out[2*g+1:2*g] = neg_input_sel;

      // The raw path has no flip-flop so it keeps working in stop mode.
      assign raw_async_out[g] = cmp_analog_in[g] & cmp_enable_bit;
      assign latched_sync_out[g] = sync2_reg & cmp_enable_bit;
      assign irq_out[g] = (rise_seen_flag_reg & rise_irq_enable) |
        (fall_seen_flag_reg & fall_irq_enable);

      // Read value of the control register.
      assign ctrl_rd = {cmp_enable_bit, cmp_result_bit, rise_seen_flag_reg,
        fall_seen_flag_reg, ctrl_reg[3:0]};
      assign ctrl_view[8*g+7:8*g] = ctrl_rd;
      assign mode_view[8*g+7:8*g] = mode_reg;
      assign mux_view[8*g+7:8*g] = mux_reg;
    end
  endgenerate

  // The first channel's latched result is offered to the reset logic.
  assign cmp0_reset_src_out = latched_sync_out[0];

  // Reads are combinational on the address; unmapped addresses read zero.
  always @* begin
    case (sfr_addr_in)
      `DCC_ADDR_CMP0_CONTROL: begin
        sfr_rdata_out = ctrl_view[7:0];
      end
      `DCC_ADDR_CMP1_CONTROL: begin
        sfr_rdata_out = ctrl_view[15:8];
      end
      `DCC_ADDR_CMP0_MODE: begin
        sfr_rdata_out = mode_view[7:0];
      end
      `DCC_ADDR_CMP1_MODE: begin
        sfr_rdata_out = mode_view[15:8];
      end
      `DCC_ADDR_CMP0_MUX: begin
        sfr_rdata_out = mux_view[7:0];
      end
      `DCC_ADDR_CMP1_MUX: begin
        sfr_rdata_out = mux_view[15:8];
      end
      default: begin
        sfr_rdata_out = 8'h00;
      end
    endcase
  end

endmodule

/* dv/dcc_analog_model.sv */
// Analog front end model: compares two voltages per channel.
`timescale 1ns/10ps
module dcc_analog_model (
  // Millivolt levels, upper half is the second channel
  input wire [31:0] pos_mv_in,
  input wire [31:0] neg_mv_in,
  // Comparison results
  output wire [1:0] cmp_out
);
  assign cmp_out[0] = pos_mv_in[15:0] > neg_mv_in[15:0];
  assign cmp_out[1] = pos_mv_in[31:16] > neg_mv_in[31:16];
endmodule

/* dv/dcc_top_properties.sv */
// Port checker of the comparator control block.
`timescale 1ns/10ps
module dcc_top_properties (
  // Watched ports
  input wire core_clk_in,
  input wire arst_n_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire [7:0] sfr_rdata_out,
  input wire [1:0] cmp_analog_in,
  input wire [1:0] cmp_power_en_out,
  input wire [3:0] pos_hyst_sel_out,
  input wire [3:0] neg_hyst_sel_out,
  input wire [1:0] raw_async_out,
  input wire [1:0] latched_sync_out,
  input wire [1:0] irq_out,
  input wire cmp0_reset_src_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  wire c0 = sfr_addr_in == 8'h9b && !sfr_wr_in;
  raw_follow_a: assert property (
    raw_async_out == (cmp_analog_in & cmp_power_en_out)) else $error("raw");
  off_low_a: assert property (
    (latched_sync_out & ~cmp_power_en_out) == 2'b00) else $error("off");
  reset_src_a: assert property (
    cmp0_reset_src_out == latched_sync_out[0]) else $error("rst src");
  sync_delay_a: assert property (
    $rose(latched_sync_out[0]) |-> $past(cmp_analog_in[0], 2))
    else $error("sync");
  result_bit_a: assert property (
    c0 |-> sfr_rdata_out[6] == latched_sync_out[0]) else $error("result");
  enable_bit_a: assert property (
    c0 |-> sfr_rdata_out[7] == cmp_power_en_out[0]) else $error("enable");
  hyst_out_a: assert property (sfr_addr_in == 8'h9a |->
    sfr_rdata_out[3:0] == {pos_hyst_sel_out[3:2], neg_hyst_sel_out[3:2]})
    else $error("hyst");
  rise_flag_a: assert property (
    $rose(latched_sync_out[0]) ##1 c0 |-> sfr_rdata_out[5]) else $error("rise");
  fall_flag_a: assert property ($fell(latched_sync_out[0]) &&
    cmp_power_en_out[0] ##1 c0 |-> sfr_rdata_out[4]) else $error("fall");
  cover property ($rose(irq_out[0]));
  cover property ($fell(latched_sync_out[0]));
  cover property ($rose(raw_async_out[1]));
endmodule
bind dcc_top dcc_top_properties dcc_top_properties_inst (.core_clk_in,
  .arst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_rdata_out, .cmp_analog_in,
  .cmp_power_en_out, .pos_hyst_sel_out, .neg_hyst_sel_out, .raw_async_out,
  .latched_sync_out, .irq_out, .cmp0_reset_src_out);

/* dv/tb_top.sv */
// Self-checking bench of the comparator control block.
`timescale 1ns/10ps
module tb_top;
  reg core_clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg sfr_wr_in = 1'b0;
  reg [7:0] sfr_addr_in = 8'h00;
  reg [7:0] sfr_wdata_in = 8'h00;
  reg [31:0] pos_mv = 32'h0;
  reg [31:0] neg_mv = 32'h00320032;
  wire [1:0] cmp, en, raw, lat, irq;
  wire [7:0] rd;
  wire [3:0] ph, nh, rt, ps, ns;
  wire rs;
  integer fails = 0, checks_done = 0, cyc = 0, i;
  reg [23:0] rows [0:5];
  dcc_analog_model dcc_analog_model_inst (.pos_mv_in(pos_mv),
    .neg_mv_in(neg_mv), .cmp_out(cmp));
  dcc_top dcc_top_inst (.core_clk_in, .arst_n_in, .sfr_addr_in,
    .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in(1'b0), .sfr_rdata_out(rd),
    .cmp_analog_in(cmp), .cmp_power_en_out(en), .pos_hyst_sel_out(ph),
    .neg_hyst_sel_out(nh), .resp_time_sel_out(rt), .pos_input_sel_out(ps),
    .neg_input_sel_out(ns), .raw_async_out(raw), .latched_sync_out(lat),
    .irq_out(irq), .cmp0_reset_src_out(rs));
  task chk(input [19:0] got, input [19:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge core_clk_in);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      @(negedge core_clk_in);
      sfr_wr_in = 1'b0;
      #1;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      sfr_addr_in = a;
      #1 chk(rd, e);
    end
  endtask
  task test_done;
    begin
      if (fails == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial forever #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      test_done;
    end
  end
  initial begin
    rows[0] = 24'h9bffbf;
    rows[1] = 24'h9a0f0f;
    rows[2] = 24'h9dff33;
    rows[3] = 24'h9f00cc;
    rows[4] = 24'h9e5ade;
    rows[5] = 24'h55ff00;
    repeat (3) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    chk({ph, nh, rt, ps, ns}, 20'hffb84);
    chk(irq, 2'b01);
    wr(8'h9b, 8'h8f);
    chk(irq, 2'b00);
    pos_mv = 32'h00000064;
    #1 chk(raw, 2'b01);
    repeat (4) @(negedge core_clk_in);
    rdc(8'h9b, 8'hef);
    chk({lat, irq, rs}, 5'b01011);
    wr(8'h9b, 8'h8f);
    pos_mv = 32'h0;
    repeat (4) @(negedge core_clk_in);
    rdc(8'h9b, 8'h9f);
    wr(8'h9a, 8'h80);
    pos_mv = 32'h00640064;
    wr(8'h9b, 8'h00);
    chk({raw, lat[0]}, 3'b100);
    arst_n_in = 1'b0;
    rdc(8'h9b, 8'h00);
    rdc(8'h9c, 8'h02);
    rdc(8'h9e, 8'hff);
    chk({en, irq, lat}, 6'h00);
    test_done;
  end
endmodule
